// ==== include/fastlock_pkg.sv ====
// shared constants and types for the fast-lock control block
package fastlock_pkg;
  // serial word layout
  localparam int         WORD_W    = 24;
  localparam int         SEL_W     = 3;
  localparam logic [2:0] SEL_FREQ  = 3'h0;
  localparam logic [2:0] SEL_TIMER = 3'h4;
  localparam logic [2:0] SEL_PD    = 3'h5;
  localparam logic [2:0] SEL_MUX   = 3'h6;
  // fast-lock timer word fields
  localparam int         TSEL_LSB  = 3;
  localparam int         TSEL_W    = 2;
  localparam int         CNT_LSB   = 5;
  localparam int         CNT_W     = 9;
  localparam logic [1:0] TSEL_ICP  = 2'h2;
  localparam logic [1:0] TSEL_SW3  = 2'h1;
  localparam logic [1:0] TSEL_SW12 = 2'h0;
  localparam int         NUM_TMR   = 3;
  localparam int         TMR_ICP   = 0;
  localparam int         TMR_SW3   = 1;
  localparam int         TMR_SW12  = 2;
  localparam int         TICK_DIV  = 4;
  // power-down word fields
  localparam int         PD_W       = 8;
  localparam int         PD_AMP_HI  = 7;
  localparam int         PD_AMP_LO  = 6;
  localparam int         PD_PUMP    = 5;
  localparam int         PD_CNT_RST = 4;
  localparam int         PD_FLOAT   = 3;
  localparam logic [7:0] PD_RESET   = 8'hF8;
  // diag mux and mode word fields
  localparam int         MODE_LSB    = 12;
  localparam int         MODE_W      = 4;
  localparam logic [3:0] MODE_PLAIN  = 4'h0;
  localparam logic [3:0] MODE_DITHER = 4'h3;
  localparam logic [3:0] MODE_WIDE   = 4'h9;
  localparam int         MUX_LSB     = 3;
  localparam int         MUX_W       = 4;
  localparam logic [3:0] MUX_LOW     = 4'h0;
  localparam logic [3:0] MUX_LOCK    = 4'h1;
  localparam logic [3:0] MUX_REF_DIV = 4'h2;
  localparam logic [3:0] MUX_N_DIV   = 4'h3;
  localparam logic [3:0] MUX_T_ICP   = 4'h4;
  localparam logic [3:0] MUX_T_SW12  = 4'h5;
  localparam logic [3:0] MUX_T_SW3   = 4'h6;
  // charge pump gain as a shift count: 6 is 64x, 0 is 1x
  localparam int         GAIN_W   = 3;
  localparam logic [2:0] GAIN_MAX = 3'h6;
  localparam logic [2:0] GAIN_MIN = 3'h0;
  // modulator denominator limits and repeat lengths
  localparam int          DEN_W      = 12;
  localparam logic [11:0] DEN_MIN    = 12'h00D;
  localparam logic [11:0] DEN_MIN_DI = 12'h032;
  localparam int          REP_W      = 22;
  localparam logic [21:0] REP_DITHER = 22'h200000;
  // pin synchroniser vector positions
  localparam int PIN_W     = 7;
  localparam int PIN_SCLK  = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_LE    = 2;
  localparam int PIN_PFD   = 3;
  localparam int PIN_LOCK  = 4;
  localparam int PIN_RDIV  = 5;
  localparam int PIN_NDIV  = 6;

  typedef enum logic [1:0] {RAMP_IDLE, RAMP_BOOST, RAMP_DOWN} ramp_state_t;
endpackage

// ==== include/timer_bus_if.sv ====
// carrier between the control block and one timeout counter
`timescale 1ns/1ps
interface timer_bus_if #(parameter int W = fastlock_pkg::CNT_W) ();
  logic         start;
  logic         tick;
  logic [W-1:0] load_val;
  logic         expire;
  logic         running;
  modport ctrl  (output start, tick, load_val, input expire, running);
  modport timer (input start, tick, load_val, output expire, running);
endinterface

// ==== verilog/fastlock_timeout_counter.sv ====
// one fast-lock timeout counter, loaded at a frequency write
`timescale 1ns/1ps
module fastlock_timeout_counter #(
  parameter int CNT_W = fastlock_pkg::CNT_W
) (
  input wire logic  ref_clk,
  input wire logic  reset,
  timer_bus_if.timer bus
);
  if (CNT_W < 1 || CNT_W > 16) begin : g_chk
    $error("timeout counter width out of range");
  end

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             running;
  logic             next_running;
  logic             expire;
  logic             next_expire;

  ////////////////////////////////////////////////////////////////////////////////
  // load on start, step per quarter tick, expire once at zero then hold
  always_comb begin
    next_count   = count;
    next_running = running;
    next_expire  = 1'b0;
    if (bus.start) begin
      next_count   = bus.load_val; // R24
      next_running = 1'b1;
    end else if (running && count == '0) begin
      next_running = 1'b0; // R24
      next_expire  = 1'b1;
    end else if (running && bus.tick) begin
      next_count = count - 1'b1; // R03
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count   <= '0;
      running <= 1'b0;
      expire  <= 1'b0;
    end else begin
      count   <= next_count;
      running <= next_running;
      expire  <= next_expire;
    end
  end

  assign bus.expire  = expire;
  assign bus.running = running;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_tmr_load: assert property ( // R24
    bus.start |=> (count == $past(bus.load_val)) && running)
    else $error("timer did not load its count");
  a_tmr_step: assert property ( // R03
    running && !bus.start && bus.tick && count != '0 |=> count == $past(count) - 1'b1)
    else $error("timer did not step on a tick");
  a_tmr_expire: assert property ( // R24
    running && !bus.start && count == '0 |=> expire && !running ##1 !expire)
    else $error("timer expiry wrong");
  a_tmr_hold: assert property ( // R24
    !running && !bus.start |=> !running && count == $past(count))
    else $error("expired timer moved");
  c_tmr_expire: cover property (running ##1 expire);
endmodule

// ==== verilog/fastlock_ctrl.sv ====
// fast-lock timers, power-down and mode control fed by the three-wire link
`timescale 1ns/1ps
// Operation
// [R01] word with select bits 100 goes to the fast-lock timer register
// [R02] host writes 0x001 into timer word bits 23 to 14
// [R03] counters step once per four phase-detector periods
// [R04] timer select 10 ramp timer, 01 secondary switch, 00 loop resistors
// [R05] a frequency word write starts all three timeout counters
// [R06] switches stay closed until their counter expires, then open
// [R07] ramp expiry halves pump current six times, 64x down to 1x
// [R08] host loads switch timers seven above the ramp timer
// [R09] host clears power-down and programs registers before leaving power-down
// [R10] word with select bits 101 goes to the power-down register
// [R11] bits 7 and 6 both set power down amplifier, both clear resume
// [R12] bit 5 holds dividers, floats pump, resets lock detect, stops ref buffer
// [R13] host clears bit 5 then writes the frequency word to resume
// [R14] float bit set puts pump outputs in high impedance
// [R15] counter reset bit holds dividers until cleared and frequency rewritten
// [R16] word with select bits 110 goes to the diag mux and mode register
// [R17] mode 0000 plain 3 ns, 0011 dither on, 1001 10 ns threshold
// [R18] host writes mode zero first before any dither or threshold write
// [R19] host writes 00001 into mux word bits 11 to 7
// [R20] diag output shows lock detect, divider outputs or a timer interval
// [R21] denominator valid from 13 to 4095, at least 50 with dither
// [R22] repeat length is 2, 3, 6 or 1 times denominator by divisibility
// [R23] dividers take new values on the phase-detector edge after the write
// [R24] counters load at the write, count down, expire once, then hold
module fastlock_ctrl #(
  parameter int PFD_PER_TICK = fastlock_pkg::TICK_DIV,
  parameter int CNT_W        = fastlock_pkg::CNT_W
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        sclk_pin,
  input  wire logic        sdata_pin,
  input  wire logic        load_strobe_pin,
  input  wire logic        pfd_ref_pin,
  input  wire logic        lock_detect_in,
  input  wire logic        ref_div_in,
  input  wire logic        n_div_in,
  input  wire logic [11:0] fraction_denominator,
  output logic             amp_power_down,
  output logic             pump_power_down,
  output logic             pump_output_float,
  output logic             divider_hold,
  output logic             lock_detect_reset,
  output logic             ref_buffer_enable,
  output logic             sw3_closed,
  output logic             sw12_closed,
  output logic [2:0]       pump_gain,
  output logic             dither_enable,
  output logic             lock_threshold_wide,
  output logic             diag_out,
  output logic             divider_update,
  output logic [21:0]      sdm_repeat_len,
  output logic             denominator_valid
);
  localparam int PW = $clog2(PFD_PER_TICK);
  localparam int NT = fastlock_pkg::NUM_TMR;

  if (PFD_PER_TICK < 2 || (PFD_PER_TICK & (PFD_PER_TICK - 1)) != 0) begin : g_chk_div
    $error("quarter-rate divider must be a power of two");
  end
  if (CNT_W != fastlock_pkg::CNT_W) begin : g_chk_cnt
    $error("timer width is fixed by the serial word layout");
  end

  // true when the word's select bits carry the given code
  function automatic logic sel_is(input logic [23:0] w, input logic [2:0] code);
    return w[fastlock_pkg::SEL_W-1:0] == code;
  endfunction

  // timer select code that loads counter number idx
  function automatic logic [1:0] tsel_of(input int idx);
    case (idx)
      fastlock_pkg::TMR_ICP: return fastlock_pkg::TSEL_ICP;
      fastlock_pkg::TMR_SW3: return fastlock_pkg::TSEL_SW3;
      default:               return fastlock_pkg::TSEL_SW12;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: stage a feeds only stage b, history finds edges
  logic [fastlock_pkg::PIN_W-1:0] pin_raw;
  logic [fastlock_pkg::PIN_W-1:0] sync_a;
  logic [fastlock_pkg::PIN_W-1:0] sync_b;
  logic [fastlock_pkg::PIN_W-1:0] sync_h;
  logic                           sclk_rise;
  logic                           le_rise;
  logic                           pfd_rise;

  assign pin_raw = {n_div_in, ref_div_in, lock_detect_in, pfd_ref_pin, load_strobe_pin, sdata_pin, sclk_pin};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_h <= '0;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      sync_h <= sync_b;
    end
  end

  // link clock and phase-detector reference are sampled, never used as clocks
  assign sclk_rise = sync_b[fastlock_pkg::PIN_SCLK] & ~sync_h[fastlock_pkg::PIN_SCLK];
  assign le_rise   = sync_b[fastlock_pkg::PIN_LE] & ~sync_h[fastlock_pkg::PIN_LE];
  assign pfd_rise  = sync_b[fastlock_pkg::PIN_PFD] & ~sync_h[fastlock_pkg::PIN_PFD];

  ////////////////////////////////////////////////////////////////////////////////
  // serial shift and register dispatch on the load strobe edge
  logic [23:0]      shreg;
  logic [23:0]      next_shreg;
  logic [CNT_W-1:0] tmr_load [NT];
  logic [CNT_W-1:0] next_tmr_load [NT];
  logic [7:0]       pd_word;
  logic [7:0]       next_pd_word;
  logic             amp_pd;
  logic             next_amp_pd;
  logic             dither_q;
  logic             next_dither;
  logic             wide_q;
  logic             next_wide;
  logic [3:0]       mux_sel;
  logic [3:0]       next_mux_sel;
  logic             wr_freq;
  logic             wr_timer;
  logic             wr_pd;
  logic             wr_mux;
  logic [3:0]       mode_f;

  assign wr_freq  = le_rise & sel_is(shreg, fastlock_pkg::SEL_FREQ);
  assign wr_timer = le_rise & sel_is(shreg, fastlock_pkg::SEL_TIMER); // R01
  assign wr_pd    = le_rise & sel_is(shreg, fastlock_pkg::SEL_PD); // R10
  assign wr_mux   = le_rise & sel_is(shreg, fastlock_pkg::SEL_MUX); // R16
  assign mode_f   = shreg[fastlock_pkg::MODE_LSB +: fastlock_pkg::MODE_W];

  always_comb begin
    next_shreg   = sclk_rise ? {shreg[22:0], sync_b[fastlock_pkg::PIN_SDATA]} : shreg;
    next_pd_word = pd_word;
    next_amp_pd  = amp_pd;
    next_dither  = dither_q;
    next_wide    = wide_q;
    next_mux_sel = mux_sel;
    for (int i = 0; i < NT; i++) begin
      next_tmr_load[i] = tmr_load[i];
      if (wr_timer && shreg[fastlock_pkg::TSEL_LSB +: fastlock_pkg::TSEL_W] == tsel_of(i)) begin
        next_tmr_load[i] = shreg[fastlock_pkg::CNT_LSB +: CNT_W]; // R04
      end
    end
    if (wr_pd) begin
      next_pd_word = shreg[fastlock_pkg::PD_W-1:0];
      // mixed amplifier bits leave the amplifier as it was
      if (shreg[fastlock_pkg::PD_AMP_HI] && shreg[fastlock_pkg::PD_AMP_LO]) begin
        next_amp_pd = 1'b1; // R11
      end else if (!shreg[fastlock_pkg::PD_AMP_HI] && !shreg[fastlock_pkg::PD_AMP_LO]) begin
        next_amp_pd = 1'b0; // R11
      end
    end
    if (wr_mux) begin
      next_mux_sel = shreg[fastlock_pkg::MUX_LSB +: fastlock_pkg::MUX_W];
      // dither and threshold writes touch one setting, plain clears both; unknown codes change nothing
      case (mode_f)
        fastlock_pkg::MODE_PLAIN: begin
          next_dither = 1'b0; // R17
          next_wide   = 1'b0;
        end
        fastlock_pkg::MODE_DITHER: next_dither = 1'b1; // R17
        fastlock_pkg::MODE_WIDE:   next_wide   = 1'b1; // R17
        default: next_dither = dither_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shreg    <= '0;
      tmr_load <= '{default: '0};
      pd_word  <= fastlock_pkg::PD_RESET;
      amp_pd   <= 1'b1;
      dither_q <= 1'b0;
      wide_q   <= 1'b0;
      mux_sel  <= fastlock_pkg::MUX_LOW;
    end else begin
      shreg    <= next_shreg;
      tmr_load <= next_tmr_load;
      pd_word  <= next_pd_word;
      amp_pd   <= next_amp_pd;
      dither_q <= next_dither;
      wide_q   <= next_wide;
      mux_sel  <= next_mux_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timeout counters, one per timer select code
  timer_bus_if #(.W(CNT_W)) tb [NT] ();
  logic          start_q;
  logic          tick_q;
  logic [NT-1:0] tmr_exp;
  logic [NT-1:0] tmr_run;

  for (genvar g = 0; g < NT; g++) begin : g_tmr
    assign tb[g].start    = start_q; // R05
    assign tb[g].tick     = tick_q;
    assign tb[g].load_val = tmr_load[g];
    assign tmr_exp[g]     = tb[g].expire;
    assign tmr_run[g]     = tb[g].running;
    fastlock_timeout_counter #(.CNT_W(CNT_W)) u_tmr (
      .ref_clk (ref_clk),
      .reset   (reset),
      .bus     (tb[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // quarter-rate tick, pump ramp, divider hold and update strobe
  logic [PW-1:0]             pre;
  logic [PW-1:0]             next_pre;
  logic                      next_start;
  logic                      next_tick;
  fastlock_pkg::ramp_state_t state;
  fastlock_pkg::ramp_state_t next_state;
  logic [2:0]                gain;
  logic [2:0]                next_gain;
  logic                      hold_q;
  logic                      next_hold;
  logic                      pend;
  logic                      next_pend;
  logic                      upd_q;
  logic                      next_upd;

  always_comb begin
    next_start = wr_freq;
    // prescaler restarts at the write so every delay is exactly count x4
    next_pre   = wr_freq ? '0 : (pfd_rise ? PW'(pre + 1'b1) : pre);
    next_tick  = pfd_rise && !wr_freq && pre == {PW{1'b1}}; // R03
    next_state = state;
    next_gain  = gain;
    case (state)
      fastlock_pkg::RAMP_IDLE:  next_state = state;
      fastlock_pkg::RAMP_BOOST: if (tmr_exp[fastlock_pkg::TMR_ICP]) next_state = fastlock_pkg::RAMP_DOWN;
      fastlock_pkg::RAMP_DOWN: begin
        if (pfd_rise) begin
          if (gain == fastlock_pkg::GAIN_MIN) next_state = fastlock_pkg::RAMP_IDLE;
          else next_gain = gain - 3'h1; // R07
        end
      end
      default: next_state = fastlock_pkg::RAMP_IDLE;
    endcase
    if (start_q) begin
      next_state = fastlock_pkg::RAMP_BOOST;
      next_gain  = fastlock_pkg::GAIN_MAX;
    end
    // held dividers release only on a frequency write after both bits clear
    if (pd_word[fastlock_pkg::PD_PUMP] || pd_word[fastlock_pkg::PD_CNT_RST]) next_hold = 1'b1; // R12 R15
    else next_hold = wr_freq ? 1'b0 : hold_q; // R15
    next_pend = wr_freq ? 1'b1 : (pend & ~pfd_rise);
    next_upd  = pend & pfd_rise & ~wr_freq; // R23
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pre     <= '0;
      start_q <= 1'b0;
      tick_q  <= 1'b0;
      state   <= fastlock_pkg::RAMP_IDLE;
      gain    <= fastlock_pkg::GAIN_MIN;
      hold_q  <= 1'b1;
      pend    <= 1'b0;
      upd_q   <= 1'b0;
    end else begin
      pre     <= next_pre;
      start_q <= next_start;
      tick_q  <= next_tick;
      state   <= next_state;
      gain    <= next_gain;
      hold_q  <= next_hold;
      pend    <= next_pend;
      upd_q   <= next_upd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered outputs: switches, power effects, diag mux, modulator length
  logic        next_float;
  logic        next_sw3;
  logic        next_sw12;
  logic        next_diag;
  logic [21:0] next_rep;
  logic        next_den_ok;
  logic        by2;
  logic        by3;
  logic [21:0] den_w;

  always_comb begin
    den_w      = {10'h000, fraction_denominator};
    by2        = ~fraction_denominator[0];
    by3        = (fraction_denominator % 12'h003) == 12'h000;
    next_float = pd_word[fastlock_pkg::PD_FLOAT] | pd_word[fastlock_pkg::PD_PUMP]; // R14 R12
    next_sw3   = tmr_run[fastlock_pkg::TMR_SW3]; // R06
    next_sw12  = tmr_run[fastlock_pkg::TMR_SW12]; // R06
    case (mux_sel)
      fastlock_pkg::MUX_LOCK:    next_diag = sync_b[fastlock_pkg::PIN_LOCK] & ~pd_word[fastlock_pkg::PD_PUMP]; // R20
      fastlock_pkg::MUX_REF_DIV: next_diag = sync_b[fastlock_pkg::PIN_RDIV]; // R20
      fastlock_pkg::MUX_N_DIV:   next_diag = sync_b[fastlock_pkg::PIN_NDIV];
      fastlock_pkg::MUX_T_ICP:   next_diag = tmr_run[fastlock_pkg::TMR_ICP]; // R20
      fastlock_pkg::MUX_T_SW12:  next_diag = tmr_run[fastlock_pkg::TMR_SW12];
      fastlock_pkg::MUX_T_SW3:   next_diag = tmr_run[fastlock_pkg::TMR_SW3];
      default:                   next_diag = 1'b0;
    endcase
    // dithered sequences are effectively non-repeating
    if (dither_q) next_rep = fastlock_pkg::REP_DITHER;
    else if (by2 && by3) next_rep = 22'(den_w * 22'h000006); // R22
    else if (by2) next_rep = 22'(den_w * 22'h000002); // R22
    else if (by3) next_rep = 22'(den_w * 22'h000003); // R22
    else next_rep = den_w;
    next_den_ok = fraction_denominator >= (dither_q ? fastlock_pkg::DEN_MIN_DI : fastlock_pkg::DEN_MIN); // R21
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pump_output_float <= 1'b1;
      lock_detect_reset <= 1'b1;
      ref_buffer_enable <= 1'b0;
      pump_power_down   <= 1'b1;
      sw3_closed        <= 1'b0;
      sw12_closed       <= 1'b0;
      diag_out          <= 1'b0;
      sdm_repeat_len    <= '0;
      denominator_valid <= 1'b0;
    end else begin
      pump_output_float <= next_float;
      lock_detect_reset <= pd_word[fastlock_pkg::PD_PUMP]; // R12
      ref_buffer_enable <= ~pd_word[fastlock_pkg::PD_PUMP]; // R12
      pump_power_down   <= pd_word[fastlock_pkg::PD_PUMP];
      sw3_closed        <= next_sw3;
      sw12_closed       <= next_sw12;
      diag_out          <= next_diag;
      sdm_repeat_len    <= next_rep;
      denominator_valid <= next_den_ok;
    end
  end

  assign amp_power_down      = amp_pd;
  assign dither_enable       = dither_q;
  assign lock_threshold_wide = wide_q;
  assign pump_gain           = gain;
  assign divider_hold        = hold_q;
  assign divider_update      = upd_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_sel_timer_load: assert property ( // R04
    wr_timer && shreg[4:3] == 2'h2 |=> tmr_load[0] == $past(shreg[13:5]))
    else $error("ramp timer not loaded by select 10");
  a_freq_start: assert property ( // R05
    wr_freq |=> start_q ##1 (&tmr_run))
    else $error("frequency write did not start all counters");
  a_amp_pd: assert property ( // R11
    wr_pd && shreg[7:6] == 2'h3 |=> amp_power_down)
    else $error("amplifier not powered down");
  a_pump_pd: assert property ( // R12
    pd_word[5] |=> divider_hold && pump_output_float && !ref_buffer_enable && lock_detect_reset)
    else $error("pump power-down effects missing");
  a_float_pin: assert property ( // R14
    wr_pd && shreg[3] |=> ##1 pump_output_float)
    else $error("pump outputs not floated");
  a_gain_step: assert property ( // R07
    state == fastlock_pkg::RAMP_DOWN && pfd_rise && gain != 3'h0 && !start_q |=> gain == $past(gain) - 3'h1)
    else $error("pump gain did not halve");
  a_ramp_start: assert property ( // R07
    state == fastlock_pkg::RAMP_BOOST && tmr_exp[0] && !start_q |=> state == fastlock_pkg::RAMP_DOWN && gain == 3'h6)
    else $error("ramp did not begin at 64x");
  a_mode_dither: assert property ( // R17
    wr_mux && shreg[15:12] == 4'h3 |=> dither_enable && $stable(lock_threshold_wide))
    else $error("dither mode write wrong");
  a_switch_open: assert property ( // R06
    1'b1 |=> sw12_closed == $past(tmr_run[2]) && sw3_closed == $past(tmr_run[1]))
    else $error("switch does not follow its counter");
  a_rep_even: assert property ( // R22
    !dither_enable && !fraction_denominator[0] && (fraction_denominator % 12'h003) != 12'h000
    |=> sdm_repeat_len == 22'($past(fraction_denominator) * 2))
    else $error("repeat length for even denominator wrong");
  a_div_update: assert property ( // R23
    wr_freq |-> ##[1:60] divider_update)
    else $error("divider update strobe missing");
  c_ramp_done: cover property (state == fastlock_pkg::RAMP_DOWN && gain == 3'h0);
  c_pd_write: cover property (wr_pd ##[1:10] pump_power_down);
  c_mode_wide: cover property (wr_mux ##1 lock_threshold_wide);
endmodule

// ==== dv/host_link_model.sv ====
// host model driving the three-wire link
`timescale 1ns/1ps
module host_link_model (
  output logic sclk,
  output logic sdata,
  output logic strobe
);
  initial {sclk, sdata, strobe} = 3'h0;
  // msb first; clock rests low between words
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      sdata = w[i];
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
    // released data shows the inverse, never a stale bit
    sdata = ~w[0];
    #100 strobe = 1'b1;
    #200 strobe = 1'b0;
  endtask
endmodule

// ==== dv/fastlock_ctrl_tb.sv ====
// self-checking bench for the fast-lock control block
`timescale 1ns/1ps
module fastlock_ctrl_tb;
  logic        ref_clk = 1'b0, reset = 1'b1, lock_detect_in = 1'b0, amp = 1'b1, hold = 1'b1, di = 1'b0;
  logic        pfd_ref_pin = 1'b0, ref_div_in = 1'b0, n_div_in = 1'b0, sclk_pin, sdata_pin, load_strobe_pin;
  logic        amp_power_down, pump_power_down, pump_output_float, divider_hold, lock_detect_reset;
  logic        ref_buffer_enable, sw3_closed, sw12_closed, dither_enable, lock_threshold_wide, diag_out;
  logic        denominator_valid, wide = 1'b0, divider_update;
  logic [2:0]  rd = 3'h0;
  logic [2:0]  pump_gain;
  logic [21:0] sdm_repeat_len;
  logic [11:0] fraction_denominator = 12'h041;
  logic [11:0] dens[9] = '{12'h031, 12'h00C, 12'h032, 12'h00D, 12'h00E, 12'h00F, 12'h012, 12'hFFF, 12'h041};
  logic [7:0]  pd = 8'hF8, pds[10] = '{8'h25, 8'h05, 8'h0D, 8'h15, 8'h05, 8'h45, 8'hC5, 8'h85, 8'h05, 8'hFF};
  logic [3:0]  k = 4'h0, modes[4] = '{4'h0, 4'h9, 4'h0, 4'h3}, mx = 4'h0;
  logic [31:0] q[$], qt[$];
  int          n_mismatch = 0, num_checks = 0, len = 0, sw = 0, n_upd = 0, nd = 0;
  event        chk;
  wire [31:0]  obs = {amp_power_down, pump_power_down, pump_output_float, divider_hold, lock_detect_reset,
    ref_buffer_enable, dither_enable, lock_threshold_wide, diag_out, denominator_valid, sdm_repeat_len};
  fastlock_ctrl fastlock_ctrl_inst (.ref_clk, .reset, .sclk_pin, .sdata_pin, .load_strobe_pin, .pfd_ref_pin,
    .lock_detect_in, .ref_div_in, .n_div_in, .fraction_denominator, .amp_power_down, .pump_power_down,
    .pump_output_float, .divider_hold, .lock_detect_reset, .ref_buffer_enable, .sw3_closed, .sw12_closed,
    .pump_gain, .dither_enable, .lock_threshold_wide, .diag_out, .divider_update, .sdm_repeat_len,
    .denominator_valid);
  host_link_model host_link_model_inst (.sclk(sclk_pin), .sdata(sdata_pin), .strobe(load_strobe_pin));
  always #12.5 ref_clk = ~ref_clk;
  // phase-detector reference at a quarter of the clock, divider outputs slower
  always @(negedge ref_clk) begin
    k <= k + 4'h1;
    {n_div_in, ref_div_in, pfd_ref_pin} <= k[3:1];
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // expected status from the bench's own copy of the written state
  function automatic logic [31:0] ev();
    int m;
    m = fraction_denominator % 6 == 0 ? 6 : fraction_denominator % 3 == 0 ? 3 : fraction_denominator % 2 == 0 ? 2 : 1;
    return {amp, pd[5], pd[5] | pd[3], hold, pd[5], ~pd[5], di, wide,
      (mx == fastlock_pkg::MUX_LOCK ? lock_detect_in & ~pd[5] : mx == fastlock_pkg::MUX_REF_DIV & rd[1]),
      fraction_denominator >= (di ? 12'h032 : 12'h00D), di ? 22'h200000 : 22'(m * fraction_denominator)};
  endfunction
  task automatic note();
    q.push_back(ev());
    ->chk;
  endtask
  // a frequency word waits out the fast-lock intervals before the next word
  task automatic wr(input logic [23:0] w);
    if (w[2:0] == 3'h6) mx = 4'h0; // diag checks rest while the mux changes over
    host_link_model_inst.send(w);
    if (w[2:0] == 3'h6) mx = w[6:3];
    if (w[2:0] == 3'h5) begin
      pd = w[7:0];
      amp = pd[7:6] == 2'h3 | (amp & pd[7:6] != 2'h0);
      hold = hold | pd[5] | pd[4];
    end
    if (w[2:0] == 3'h0) begin
      hold = pd[5] | pd[4];
      qt.push_back(sw);
    end
    repeat (w[2:0] == 3'h0 ? 300 : 8) @(negedge ref_clk);
    note();
  endtask
  // pairs each noted expectation with the settled outputs
  initial forever begin
    @chk;
    check(obs, q.pop_front());
  end
  // switch intervals in clock cycles; one count is four reference periods
  // divider pin reaches diag three falling edges after it moves
  always @(negedge ref_clk) begin
    rd <= {rd[1:0], ref_div_in};
    if (divider_update) n_upd++;
    if (diag_out && mx == fastlock_pkg::MUX_T_ICP) nd++;
    if (mx == fastlock_pkg::MUX_REF_DIV) check(diag_out, rd[1]);
    if (sw12_closed && len == 0) check(32'(pump_gain) + 32'(sw3_closed), 32'h7);
    if (!sw12_closed && len > 0) begin
      check((len + 8) / 16, qt.pop_front());
      check(n_upd, 1);
      if (mx == fastlock_pkg::MUX_T_ICP) check((nd + 8) / 16, sw - 7);
      n_upd = 0;
      nd = 0;
      check(32'(pump_gain) + 32'(sw3_closed), 32'h0);
      len = 0;
    end
    if (sw12_closed) len++;
  end
  // hangs end through the same closing task
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h6DCD0F00));
    repeat (5) @(negedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(negedge ref_clk);
    note();
    wr(24'h000005);
    lock_detect_in <= 1'b1;
    foreach (modes[i]) begin
      di = modes[i] == 4'h3;
      wide = modes[i] == 4'h9;
      wr({8'h00, modes[i], 5'h01, fastlock_pkg::MUX_LOCK, 3'h6});
    end
    dens[8] = 12'($urandom_range(4095, 13));
    foreach (dens[i]) begin
      if (i == 3) begin
        di = 1'b0;
        wr(24'h00008E);
      end
      fraction_denominator <= dens[i];
      repeat (3) @(negedge ref_clk);
      note();
    end
    sw = $urandom_range(8, 1) + 7;
    wr({10'h001, 9'(sw - 7), fastlock_pkg::TSEL_ICP, 3'h4});
    wr({10'h001, 9'(sw), fastlock_pkg::TSEL_SW3, 3'h4});
    wr({10'h001, 9'(sw), fastlock_pkg::TSEL_SW12, 3'h4});
    wr({21'($urandom()), 3'h0});
    foreach (pds[i]) begin
      wr({16'h0000, pds[i]});
      if (pds[i] == 8'h05) wr({21'($urandom()), 3'h0});
    end
    // diag mux: divider output, then the ramp timer interval after a frequency write
    wr({8'h00, 4'h0, 5'h01, fastlock_pkg::MUX_REF_DIV, 3'h6});
    wr({8'h00, 4'h0, 5'h01, fastlock_pkg::MUX_T_ICP, 3'h6});
    wr({21'($urandom()), 3'h0});
    end_of_test();
  end
endmodule
